// ---- design/ehs_pkg.sv ----
// Package with constants for the emulator halt and host synchronisation block.
package ehs_pkg;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int unsigned IMG_WORDS   = 8;
  localparam int unsigned IMG_IDX_W   = 3;
  localparam int unsigned WORD_W      = 32;
  localparam logic [2:0]  IDX_LAST    = 3'h7;
  localparam logic [2:0]  IDX_ZERO    = 3'h0;

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    EHS_RUN   = 3'b000,
    EHS_DRAIN = 3'b001,
    EHS_DUMP  = 3'b010,
    EHS_HALT  = 3'b011,
    EHS_LOAD  = 3'b100
  } ehs_state_t;

endpackage

// ---- design/ehs_top.sv ----
// Halt and run synchronisation between the emulated processor and its host.
`timescale 1ns/1ns

// Function
// - While halted, a new host access sees chip select held high and host ready held low until running resumes.
// - A host access already in progress at a breakpoint finishes normally before halt acknowledge goes low.
// - Halt acknowledge goes low once the open access has drained and the dump starts, and returns high as the reload starts, before it runs again.
// - At a breakpoint the register image is dumped to the buffer, and reloaded on resume one index late, its last word to index 0 in the first run cycle.
// - Driving the run/halt request input low halts the emulated processor.
module ehs_top
  import ehs_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // Halt sources
  input  wire logic              run_halt_request_n_i,
  input  wire logic              breakpoint_i,
  // Host side pins
  input  wire logic              host_chip_select_n_i,
  input  wire logic              host_ready_in_i,
  output logic                   host_chip_select_n_o,
  output logic                   host_ready_out_o,
  output logic                   halt_acknowledge_n_o,
  // Processor register image port
  output logic                   proc_run_o,
  output logic [IMG_IDX_W-1:0]   img_idx_o,
  input  wire logic [WORD_W-1:0] img_rdata_i,
  output logic [WORD_W-1:0]      img_wdata_o,
  output logic                   img_we_o
);

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic       rst_s1_q;
  logic       rst_n_q;
  logic [1:0] rh_sync_q;
  logic [1:0] cs_sync_q;
  logic [1:0] bp_sync_q;
  logic       halt_req;
  logic       cs_act;

  // Reset is released through two flops so its removal is clean.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // The run/halt, select and breakpoint pins are asynchronous, so each passes two flops before use.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rh_sync_q <= 2'h3;
      cs_sync_q <= 2'h3;
      bp_sync_q <= 2'h0;
    end else begin
      rh_sync_q <= {rh_sync_q[0], run_halt_request_n_i};
      cs_sync_q <= {cs_sync_q[0], host_chip_select_n_i};
      bp_sync_q <= {bp_sync_q[0], breakpoint_i};
    end
  end

  assign halt_req = !rh_sync_q[1] || bp_sync_q[1];
  assign cs_act   = !cs_sync_q[1];

  // ----------------------------------------------------------------
  // Halt controller
  // ----------------------------------------------------------------
  ehs_state_t           state_q;
  logic [IMG_IDX_W-1:0] idx_q;
  logic                 gate_q;
  logic [WORD_W-1:0]    img_q [IMG_WORDS];

  // Next image index, shared by the dump and the reload walk.
  // The count wraps from the last word back to zero on its own.
  function automatic logic [IMG_IDX_W-1:0] next_idx(input logic [IMG_IDX_W-1:0] cur);
    return cur + IMG_IDX_W'(1);
  endfunction

  // Gate marks that new host accesses are blocked. It is armed only when
  // no access is open, so an access in flight is never cut short.
  // It stays armed through the reload and drops on the edge that enters
  // run, since a host let in while registers are restored would spoil them.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gate_q <= 1'b0;
    end else if (state_q == EHS_RUN || (state_q == EHS_LOAD && idx_q == IDX_LAST)) begin
      gate_q <= 1'b0;
    end else if (!cs_act) begin
      gate_q <= 1'b1;
    end
  end

  // Sequence: drain open access, dump image, hold, reload, run.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= EHS_RUN;
      idx_q   <= IDX_ZERO;
    end else begin
      unique case (state_q)
        EHS_RUN: begin
          if (halt_req) begin
            state_q <= EHS_DRAIN;
          end
        end
        EHS_DRAIN: begin
          if (!cs_act) begin
            state_q <= EHS_DUMP;
            idx_q   <= IDX_ZERO;
          end
        end
        EHS_DUMP: begin
          idx_q <= next_idx(idx_q);
          if (idx_q == IDX_LAST) begin
            state_q <= EHS_HALT;
          end
        end
        EHS_HALT: begin
          if (!halt_req) begin
            state_q <= EHS_LOAD;
            idx_q   <= IDX_ZERO;
          end
        end
        EHS_LOAD: begin
          idx_q <= next_idx(idx_q);
          if (idx_q == IDX_LAST) begin
            state_q <= EHS_RUN;
          end
        end
        default: begin
          state_q <= EHS_RUN;
        end
      endcase
    end
  end

  // Image buffer captures processor registers during the dump.
  always_ff @(posedge clk_i) begin
    if (state_q == EHS_DUMP) begin
      img_q[idx_q] <= img_rdata_i;
    end
  end

  // Acknowledge and write data come from flops.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      halt_acknowledge_n_o <= 1'b1;
      img_wdata_o          <= '0;
      img_we_o             <= 1'b0;
    end else begin
      halt_acknowledge_n_o <= !(state_q == EHS_DUMP || state_q == EHS_HALT);
      img_we_o             <= (state_q == EHS_LOAD);
      img_wdata_o          <= img_q[idx_q];
    end
  end

  // Blocked accesses see select high and ready low; otherwise pass through.
  // Ready is held low for as long as the halt lasts, which a host with
  // refresh duties may not survive.
  assign host_chip_select_n_o = gate_q ? 1'b1 : cs_sync_q[1];
  assign host_ready_out_o     = gate_q ? 1'b0 : host_ready_in_i;
  assign proc_run_o           = (state_q == EHS_RUN);
  assign img_idx_o            = idx_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  blocked_ready_low_a : assert property (@(posedge clk_i) disable iff (!rst_n_q)
    (state_q == EHS_HALT && cs_act) |-> (!host_ready_out_o && host_chip_select_n_o))
    else $error("Blocked access not held off.");
  drain_no_gate_a : assert property (@(posedge clk_i) disable iff (!rst_n_q)
    (state_q == EHS_DRAIN && cs_act) |-> (!gate_q && host_ready_out_o == host_ready_in_i && !host_chip_select_n_o))
    else $error("Open access was cut short.");
  ack_after_drain_a : assert property (@(posedge clk_i) disable iff (!rst_n_q)
    (state_q == EHS_DRAIN) |=> halt_acknowledge_n_o)
    else $error("Acknowledge low before access drained.");
  ack_in_halt_a : assert property (@(posedge clk_i) disable iff (!rst_n_q)
    (state_q == EHS_HALT) |=> !halt_acknowledge_n_o)
    else $error("Acknowledge not low while halted.");
  ack_release_a : assert property (@(posedge clk_i) disable iff (!rst_n_q)
    (state_q == EHS_LOAD) |=> halt_acknowledge_n_o)
    else $error("Acknowledge not released on resume.");
  dump_length_a : assert property (@(posedge clk_i) disable iff (!rst_n_q)
    $rose(state_q == EHS_DUMP) |-> (state_q == EHS_DUMP) [*8] ##1 (state_q == EHS_HALT))
    else $error("Dump length wrong.");
  load_length_a : assert property (@(posedge clk_i) disable iff (!rst_n_q)
    $rose(state_q == EHS_LOAD) |-> (state_q == EHS_LOAD) [*8] ##1 (state_q == EHS_RUN))
    else $error("Reload length wrong.");
  halt_request_a : assert property (@(posedge clk_i) disable iff (!rst_n_q)
    (state_q == EHS_RUN && !rh_sync_q[1]) |=> !proc_run_o)
    else $error("Halt request ignored.");
  // Blocking has to last through the reload, and must be gone while running.
  load_blocked_a : assert property (@(posedge clk_i) disable iff (!rst_n_q)
    (state_q == EHS_LOAD && cs_act) |-> (!host_ready_out_o && host_chip_select_n_o))
    else $error("Access not held off during reload.");
  run_pass_a : assert property (@(posedge clk_i) disable iff (!rst_n_q)
    (state_q == EHS_RUN) |-> (host_ready_out_o == host_ready_in_i && host_chip_select_n_o == cs_sync_q[1]))
    else $error("Access blocked while running.");
  dump_capture_a : assert property (@(posedge clk_i) disable iff (!rst_n_q)
    (state_q == EHS_DUMP) |=> (img_q[$past(idx_q)] == $past(img_rdata_i)))
    else $error("Dump word not captured.");

  // Covers for the halt cycle, the drain wait and the blocked host.
  halt_cycle_c   : cover property (@(posedge clk_i) disable iff (!rst_n_q)
    state_q == EHS_HALT ##[1:100] state_q == EHS_RUN);
  drain_wait_c   : cover property (@(posedge clk_i) disable iff (!rst_n_q)
    state_q == EHS_DRAIN ##3 state_q == EHS_DRAIN);
  blocked_host_c : cover property (@(posedge clk_i) disable iff (!rst_n_q)
    state_q == EHS_HALT && cs_act);
  drain_exit_c   : cover property (@(posedge clk_i) disable iff (!rst_n_q)
    (state_q == EHS_DRAIN && cs_act) ##1 (state_q == EHS_DRAIN && !cs_act) ##1 state_q == EHS_DUMP);

endmodule

// ---- verif/ehs_host_model.sv ----
// Host-side partner model: host accesses and the host emulator's run/halt line.
`timescale 1ns/1ns
module ehs_host_model (
  // Clock
  input  wire logic clk_i,
  // Commands from the bench
  input  wire logic access_i,
  input  wire logic ignore_ack_i,
  input  wire logic halt_cmd_i,
  // Pins
  input  wire logic halt_acknowledge_n_i,
  output logic      host_chip_select_n_o,
  output logic      run_halt_request_n_o
);
  logic cs_n_q = 1'b1;

  // The host emulator's halt state drives the run/halt request.
  assign run_halt_request_n_o = !halt_cmd_i;
  assign host_chip_select_n_o = cs_n_q;

  // Acknowledge acts as the host's interrupt; a polite host starts nothing while it is low.
  always @(posedge clk_i) begin
    cs_n_q <= !(access_i && (halt_acknowledge_n_i || ignore_ack_i));
  end
endmodule

// ---- verif/ehs_top_test.sv ----
// Self-checking bench for the halt and host synchronisation block.
`timescale 1ns/1ns
module ehs_top_test;
  import ehs_pkg::*;
  logic              clk, rst_b, bkpt, rdy_in, access, rude, halt_cmd, rh_n, cs_n_in;
  logic              cs_n_out, rdy_out, ack_n, run, we;
  logic [2:0]        idx;
  logic [WORD_W-1:0] wdata, mem [IMG_WORDS];
  int                seed = 14907, fails = 0, checked = 0, n;

  // ----------------------------------------------------------------
  // Design, partner and image store
  // ----------------------------------------------------------------
  ehs_top DUT (.clk_i(clk), .rst_b_i(rst_b), .run_halt_request_n_i(rh_n), .breakpoint_i(bkpt),
    .host_chip_select_n_i(cs_n_in), .host_ready_in_i(rdy_in), .host_chip_select_n_o(cs_n_out),
    .host_ready_out_o(rdy_out), .halt_acknowledge_n_o(ack_n), .proc_run_o(run), .img_idx_o(idx),
    .img_rdata_i(mem[idx]), .img_wdata_o(wdata), .img_we_o(we));
  ehs_host_model host (.clk_i(clk), .access_i(access), .ignore_ack_i(rude), .halt_cmd_i(halt_cmd),
    .halt_acknowledge_n_i(ack_n), .host_chip_select_n_o(cs_n_in), .run_halt_request_n_o(rh_n));

  // Clock at 8 ns and a random core ready, so pass-through is seen with both levels.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) rdy_in <= 1'($random(seed));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait, since a stuck acknowledge must not hang the run.
  task wait_ack(input logic lvl);
    n = 0;
    while (ack_n !== lvl && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, ack_n}, {31'h0, lvl});
  endtask

  task complete_run;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #24000;
    fails++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {bkpt, access, rude, halt_cmd} = 4'h0;
    rst_b = 1'b0;
    for (int i = 0; i < IMG_WORDS; i++) mem[i] = 32'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    // Halt from the run/halt line, then from a breakpoint; a rude host is stalled meanwhile.
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < IMG_WORDS; i++) mem[i] <= $random(seed);
      @(posedge clk);
      halt_cmd <= (s == 0);
      bkpt <= (s == 1);
      wait_ack(1'b0);
      repeat (12) @(negedge clk);
      chk({31'h0, run}, 32'h0);
      @(posedge clk);
      {access, rude} <= 2'h3;
      repeat (5) @(negedge clk);
      chk({30'h0, cs_n_out, rdy_out}, 32'h2);
      @(posedge clk);
      {access, rude, halt_cmd, bkpt} <= 4'h0;
      n = 0;
      for (int c = 0; c < 40; c++) begin
        @(negedge clk);
        if (we === 1'b1) begin
          chk(wdata, mem[n[2:0]]);
          n++;
        end
      end
      chk(n, IMG_WORDS);
      chk({30'h0, ack_n, run}, 32'h3);
    end
    // Breakpoint during an access in progress: it finishes untouched before acknowledge.
    @(posedge clk);
    access <= 1'b1;
    repeat (6) @(posedge clk);
    bkpt <= 1'b1;
    repeat (8) begin
      @(negedge clk);
      chk({29'h0, cs_n_out, ack_n, rdy_out}, {29'h0, 1'b0, 1'b1, rdy_in});
    end
    @(posedge clk);
    access <= 1'b0;
    wait_ack(1'b0);
    @(posedge clk);
    bkpt <= 1'b0;
    wait_ack(1'b1);
    // Reset while halted: outputs fall back to idle and the block runs after release.
    @(posedge clk);
    halt_cmd <= 1'b1;
    wait_ack(1'b0);
    @(posedge clk);
    rst_b <= 1'b0;
    halt_cmd <= 1'b0;
    @(negedge clk);
    chk({29'h0, ack_n, run, cs_n_out}, 32'h7);
    chk({31'h0, we}, 32'h0);
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(negedge clk);
    chk({30'h0, ack_n, run}, 32'h3);
    complete_run();
  end
endmodule
